// file: rtl/gph_ports.sv
// Two 8-bit GPIO ports with function routing, boot strap capture and AXI4-Lite registers.
// Behaviour
// - Eight pins per port, each pin's input and output enabled separately.
// - First-port bit 7 set routes pin 7 to timer output.
// - First-port bits 6 and 2 route pins to serial clocks of channels two, zero.
// - First-port bits 5 and 1 route pins to serial data inputs or I2C clock.
// - First-port bits 4 and 0 route pins to serial data outputs or I2C data.
// - First-port bit 3 set connects pin 3 to external interrupt four.
// - Drive-type bit zero gives CMOS output, one gives open-drain; resets zero.
// - First-port pull-up bit one enables internal pull-up; resets zero.
// - First-port input-enable bit one passes pin input; resets zero.
// - Second-port pins feed timer inputs; pin 0 is also the boot strap.
// - While reset is low, strap input path and pull-up are forced on.
// - At reset release a high strap selects booting from on-chip flash.
// - A low strap at reset release selects the internal boot program.
// - After reset second-port pins are GPIO with input and output disabled.
// - After reset second-port pull-up is on for pin 0 only.
// - Second-port registers sit at data, output, function, pull-up, input offsets.
// - Second-port data register holds eight read/write bits, reset zero.
// - Second-port output-control bit one enables the pin driver where the function bit is zero; resets zero.
// - Second-port function bit one routes pins to timer capture inputs.
// - Outside stop mode interrupt four passes whenever its input is enabled.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/100ps

module gph_ports
(
   // Clock and reset.
   input  wire logic                  I_REF_CLK,
   input  wire logic                  I_RSTN,
   // Register bus.
   input  wire gph_pkg::gph_axi_req_t I_AXI_REQ,
   output      gph_pkg::gph_axi_rsp_t O_AXI_RSP,
   // First port pins.
   input  wire logic [7:0]            I_FP_PIN_I,
   output      gph_pkg::gph_pad_t     O_FP_PAD,
   // First port GPIO side and peripheral side.
   input  wire gph_pkg::gph_drive_t   I_FP_GPIO_DRV,
   output      logic [7:0]            O_FP_GPIO_I,
   input  wire gph_pkg::gph_drive_t   I_FP_ALT_DRV,
   output      logic [7:0]            O_FP_ALT_I,
   // Interrupt path.
   input  wire logic                  I_STOP_MODE,
   output      logic                  O_EXT_INT_FOUR,
   // Second port pins and timer capture inputs.
   input  wire logic [7:0]            I_SP_PIN_I,
   output      gph_pkg::gph_pad_t     O_SP_PAD,
   output      logic [7:0]            O_SP_TIMER_CAP,
   // Boot selection.
   output      logic                  O_BOOT_VALID,
   output      logic                  O_BOOT_FLASH,
   output      logic                  O_BOOT_ROM
);
   import gph_pkg::*;

   // Whole state of the block.
   typedef struct packed {
      logic              aw_held;
      logic [ADDR_W-1:0] aw_addr;
      logic              w_held;
      logic [7:0]        w_byte;
      logic              w_lane0;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        rresp;
      logic [7:0]        fp_fsel;
      logic [7:0]        fp_od;
      logic [7:0]        fp_pup;
      logic [7:0]        fp_ie;
      logic [7:0]        sp_data;
      logic [7:0]        sp_oe;
      logic [7:0]        sp_fsel;
      logic [7:0]        sp_pup;
      logic [7:0]        sp_ie;
      gph_pad_t          fp_pad;
      gph_pad_t          sp_pad;
      logic [7:0]        fp_gpio_i;
      logic [7:0]        fp_alt_i;
      logic              ext_int;
      logic [7:0]        sp_cap;
      logic              boot_valid;
      logic              boot_flash;
   } gph_state_t;

   gph_state_t st_r;
   gph_state_t st_nxt;

   // Combinational helper terms.
   logic             aw_take;
   logic             w_take;
   logic             ar_take;
   logic [7:0]       fp_in_g;
   logic [7:0]       sp_in_g;
   logic [7:0]       fp_sel_o;
   logic [7:0]       fp_sel_oe;
   logic [7:0]       sp_rd_data;

   // Write address and data are accepted separately while no response waits.
   assign aw_take = I_AXI_REQ.awvalid && !st_r.aw_held && !st_r.bvalid;
   assign w_take  = I_AXI_REQ.wvalid && !st_r.w_held && !st_r.bvalid;
   assign ar_take = I_AXI_REQ.arvalid && !st_r.rvalid;

   // Pin inputs pass only where the input enable is set.
   assign fp_in_g    = I_FP_PIN_I & st_r.fp_ie;
   assign sp_in_g    = I_SP_PIN_I & st_r.sp_ie;
   // Data reads show the pin where input is enabled and the latch elsewhere.
   assign sp_rd_data = (st_r.sp_data & ~st_r.sp_ie) | sp_in_g;

   // First-port source select: function bit picks peripheral, else GPIO.
   assign fp_sel_o  = (I_FP_ALT_DRV.o & st_r.fp_fsel) | (I_FP_GPIO_DRV.o & ~st_r.fp_fsel);
   assign fp_sel_oe = (I_FP_ALT_DRV.oe & st_r.fp_fsel) | (I_FP_GPIO_DRV.oe & ~st_r.fp_fsel);

   // Register read mux; unused upper bits stay zero.
   function automatic logic [DATA_W-1:0] rd_word(input logic [ADDR_W-1:0] a, input gph_state_t s,
                                                  input logic [7:0] sp_rd);
      logic [DATA_W-1:0] w;
      w = '0;
      unique case (a)
         FP_FSEL_OFS:   w[7:0] = s.fp_fsel;
         FP_OD_OFS:     w[7:0] = s.fp_od;
         FP_PUP_OFS:    w[7:0] = s.fp_pup;
         FP_IE_OFS:     w[7:0] = s.fp_ie;
         SP_DATA_OFS:   w[7:0] = sp_rd;
         SP_OE_OFS:     w[7:0] = s.sp_oe;
         SP_FSEL_OFS:   w[7:0] = s.sp_fsel;
         SP_PUP_OFS:    w[7:0] = s.sp_pup;
         SP_IE_OFS:     w[7:0] = s.sp_ie;
         BOOT_STAT_OFS:
         begin
            w[BOOT_VALID_BIT] = s.boot_valid;
            w[BOOT_FLASH_BIT] = s.boot_flash;
         end
         default:       w = '0;
      endcase
      return w;
   endfunction

   // Address is mapped when it names a register of the window.
   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      logic m;
      m = 1'b0;
      unique case (a)
         FP_FSEL_OFS, FP_OD_OFS, FP_PUP_OFS, FP_IE_OFS,
         SP_DATA_OFS, SP_OE_OFS, SP_FSEL_OFS, SP_PUP_OFS, SP_IE_OFS,
         BOOT_STAT_OFS: m = 1'b1;
         default:       m = 1'b0;
      endcase
      return m;
   endfunction

   // Next-state logic of bus slave, registers, pads and boot capture.
   always_comb
   begin
      st_nxt = st_r;

      // Capture write address and data in either order.
      if (aw_take)
      begin
         st_nxt.aw_held = 1'b1;
         st_nxt.aw_addr = I_AXI_REQ.awaddr;
      end
      if (w_take)
      begin
         st_nxt.w_held  = 1'b1;
         st_nxt.w_byte  = I_AXI_REQ.wdata[7:0];
         st_nxt.w_lane0 = I_AXI_REQ.wstrb[0];
      end

      // Perform the write once both halves are held.
      if (st_r.aw_held && st_r.w_held && !st_r.bvalid)
      begin
         st_nxt.aw_held = 1'b0;
         st_nxt.w_held  = 1'b0;
         st_nxt.bvalid  = 1'b1;
         st_nxt.bresp   = is_mapped(st_r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
         if (st_r.w_lane0)
         begin
            unique case (st_r.aw_addr)
               FP_FSEL_OFS: st_nxt.fp_fsel = st_r.w_byte;
               FP_OD_OFS:   st_nxt.fp_od   = st_r.w_byte;
               FP_PUP_OFS:  st_nxt.fp_pup  = st_r.w_byte;
               FP_IE_OFS:   st_nxt.fp_ie   = st_r.w_byte;
               SP_DATA_OFS: st_nxt.sp_data = st_r.w_byte;
               SP_OE_OFS:   st_nxt.sp_oe   = st_r.w_byte;
               SP_FSEL_OFS: st_nxt.sp_fsel = st_r.w_byte;
               SP_PUP_OFS:  st_nxt.sp_pup  = st_r.w_byte;
               SP_IE_OFS:   st_nxt.sp_ie   = st_r.w_byte;
               default:     st_nxt.bvalid  = 1'b1;
            endcase
         end
      end

      // Write response retires when the master takes it.
      if (st_r.bvalid && I_AXI_REQ.bready)
      begin
         st_nxt.bvalid = 1'b0;
      end

      // Read: data registered in the cycle of acceptance.
      if (ar_take)
      begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata  = rd_word(I_AXI_REQ.araddr, st_r, sp_rd_data);
         st_nxt.rresp  = is_mapped(I_AXI_REQ.araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (st_r.rvalid && I_AXI_REQ.rready)
      begin
         st_nxt.rvalid = 1'b0;
      end

      // First-port pads: open-drain never drives high.
      st_nxt.fp_pad.o       = fp_sel_o & ~st_r.fp_od;
      st_nxt.fp_pad.oe      = fp_sel_oe & (~st_r.fp_od | ~fp_sel_o);
      st_nxt.fp_pad.pull_en = st_r.fp_pup;
      st_nxt.fp_pad.in_en   = st_r.fp_ie;

      // First-port inputs towards GPIO logic and peripherals.
      st_nxt.fp_gpio_i = fp_in_g & ~st_r.fp_fsel;
      st_nxt.fp_alt_i  = fp_in_g & st_r.fp_fsel;
      // Interrupt four needs the function bit only in stop mode.
      st_nxt.ext_int   = fp_in_g[INT_PIN] && (st_r.fp_fsel[INT_PIN] || !I_STOP_MODE);

      // Second-port pads: timer function pins are inputs only.
      st_nxt.sp_pad.o       = st_r.sp_data;
      st_nxt.sp_pad.oe      = st_r.sp_oe & ~st_r.sp_fsel;
      st_nxt.sp_pad.pull_en = st_r.sp_pup;
      st_nxt.sp_pad.in_en   = st_r.sp_ie;
      st_nxt.sp_cap         = sp_in_g & st_r.sp_fsel;

      // Strap is sampled on the first edge after reset release, once.
      if (!st_r.boot_valid)
      begin
         st_nxt.boot_valid = 1'b1;
         st_nxt.boot_flash = I_SP_PIN_I[BOOT_PIN];
      end
   end

   // State register; reset values are constants only.
   always_ff @(posedge I_REF_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         st_r                <= '0;
         st_r.bresp          <= RESP_OKAY;
         st_r.rresp          <= RESP_OKAY;
         st_r.fp_fsel        <= FP_FSEL_RST;
         st_r.fp_od          <= FP_OD_RST;
         st_r.fp_pup         <= FP_PUP_RST;
         st_r.fp_ie          <= FP_IE_RST;
         st_r.sp_data        <= SP_DATA_RST;
         st_r.sp_oe          <= SP_OE_RST;
         st_r.sp_fsel        <= SP_FSEL_RST;
         st_r.sp_pup         <= SP_PUP_RST;
         st_r.sp_ie          <= SP_IE_RST;
         st_r.sp_pad.in_en   <= SP_IN_EN_RST;
         st_r.sp_pad.pull_en <= SP_PULL_EN_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // Bus answers; ready terms are combinational.
   assign O_AXI_RSP.awready = !st_r.aw_held && !st_r.bvalid;
   assign O_AXI_RSP.wready  = !st_r.w_held && !st_r.bvalid;
   assign O_AXI_RSP.bvalid  = st_r.bvalid;
   assign O_AXI_RSP.bresp   = st_r.bresp;
   assign O_AXI_RSP.arready = !st_r.rvalid;
   assign O_AXI_RSP.rvalid  = st_r.rvalid;
   assign O_AXI_RSP.rdata   = st_r.rdata;
   assign O_AXI_RSP.rresp   = st_r.rresp;

   // Pin and peripheral outputs straight from the state register.
   assign O_FP_PAD       = st_r.fp_pad;
   assign O_FP_GPIO_I    = st_r.fp_gpio_i;
   assign O_FP_ALT_I     = st_r.fp_alt_i;
   assign O_EXT_INT_FOUR = st_r.ext_int;
   assign O_SP_PAD       = st_r.sp_pad;
   assign O_SP_TIMER_CAP = st_r.sp_cap;
   assign O_BOOT_VALID   = st_r.boot_valid;
   assign O_BOOT_FLASH   = st_r.boot_valid && st_r.boot_flash;
   assign O_BOOT_ROM     = st_r.boot_valid && !st_r.boot_flash;

   // Checks on the design's own behaviour.
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RSTN);

   rd_upper_zero_a: assert property (st_r.rvalid |-> st_r.rdata[31:8] == 24'h000000)
      else $error("upper read bits not zero");

   boot_capture_a: assert property ($rose(st_r.boot_valid) |-> st_r.boot_flash == $past(I_SP_PIN_I[BOOT_PIN]))
      else $error("strap level not captured at release");

   boot_hold_a: assert property (st_r.boot_valid |=> st_r.boot_valid && $stable(st_r.boot_flash))
      else $error("boot selection changed after capture");

   od_no_high_a: assert property ((O_FP_PAD.oe & O_FP_PAD.o & $past(st_r.fp_od)) == 8'h00)
      else $error("open-drain pin driven high");

   sp_fsel_nodrv_a: assert property ((O_SP_PAD.oe & $past(st_r.sp_fsel)) == 8'h00)
      else $error("timer input pin driven");

   int_stop_gate_a: assert property (I_STOP_MODE && !st_r.fp_fsel[INT_PIN] |=> !O_EXT_INT_FOUR)
      else $error("interrupt passed in stop mode without function");

   int_run_pass_a: assert property (!I_STOP_MODE && I_FP_PIN_I[INT_PIN] && st_r.fp_ie[INT_PIN] |=> O_EXT_INT_FOUR)
      else $error("interrupt input not passed");

   wr_resp_a: assert property (aw_take && w_take |-> ##[1:2] st_r.bvalid)
      else $error("write response missing");

   // The response code follows the address that was accepted.
   rd_resp_a: assert property (ar_take |=> st_r.rvalid &&
      st_r.rresp == (is_mapped($past(I_AXI_REQ.araddr)) ? RESP_OKAY : RESP_SLVERR))
      else $error("read response wrong");

   pup_reset_a: assert property ($rose(I_RSTN) |-> O_SP_PAD.pull_en == 8'h01 && O_SP_PAD.in_en == 8'h01 && O_SP_PAD.oe == 8'h00)
      else $error("second port reset pad state wrong");

   // A reserved read is accepted but answered with an error.
   rsvd_read_a: assert property (ar_take && I_AXI_REQ.araddr == SP_RSVD_OFS |=> st_r.rresp == RESP_SLVERR)
      else $error("reserved read not refused");

   // A reserved write is refused and leaves the registers as they were.
   rsvd_write_a: assert property (st_r.aw_held && st_r.w_held && st_r.aw_addr == SP_RSVD_OFS
      |=> st_r.bresp == RESP_SLVERR && $stable(st_r.sp_data) && $stable(st_r.sp_oe) && $stable(st_r.fp_fsel))
      else $error("reserved write not refused");

   // No new write is taken while a response waits.
   busy_ready_a: assert property (st_r.bvalid |-> !O_AXI_RSP.awready && !O_AXI_RSP.wready)
      else $error("write taken while response waits");

   // No new read is taken while read data waits.
   rd_ready_a: assert property (st_r.rvalid |-> !O_AXI_RSP.arready)
      else $error("read taken while data waits");

   // Only an output-enabled pin may drive.
   sp_oe_gate_a: assert property ((O_SP_PAD.oe & ~$past(st_r.sp_oe)) == 8'h00)
      else $error("second port pin driven without enable");

   // A driven second-port pin shows its data bit.
   sp_out_data_a: assert property ((O_SP_PAD.oe & (O_SP_PAD.o ^ $past(st_r.sp_data))) == 8'h00)
      else $error("second port pin drives wrong level");

   // A capture input only sees pins handed to the timer.
   sp_cap_gate_a: assert property ((O_SP_TIMER_CAP & ~$past(st_r.sp_fsel)) == 8'h00)
      else $error("capture seen on GPIO pin");

   // A blocked input path keeps both receivers at zero.
   fp_ie_gate_a: assert property (((O_FP_GPIO_I | O_FP_ALT_I) & ~$past(st_r.fp_ie)) == 8'h00)
      else $error("blocked input passed");

   // A pin feeds either its GPIO side or its peripheral, never both.
   fp_route_a: assert property ((O_FP_GPIO_I & O_FP_ALT_I) == 8'h00)
      else $error("pin routed to both sides");

   // Without input enable the interrupt line stays quiet.
   int_ie_gate_a: assert property (!st_r.fp_ie[INT_PIN] |=> !O_EXT_INT_FOUR)
      else $error("interrupt passed without input enable");

   // Once captured, exactly one boot source is selected.
   boot_excl_a: assert property (O_BOOT_VALID |-> O_BOOT_FLASH != O_BOOT_ROM)
      else $error("boot source not unique");

   // Before capture no boot source is claimed.
   boot_idle_a: assert property (!O_BOOT_VALID |-> !O_BOOT_FLASH && !O_BOOT_ROM)
      else $error("boot source claimed early");

endmodule

// file: rtl/gph_pkg.sv
// Package with register map, reset values and carrier types for the two GPIO ports.
package gph_pkg;

   // Register bus geometry.
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Byte offsets of the first port inside the block window.
   localparam logic [ADDR_W-1:0] FP_FSEL_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] FP_OD_OFS   = 8'h28;
   localparam logic [ADDR_W-1:0] FP_PUP_OFS  = 8'h2c;
   localparam logic [ADDR_W-1:0] FP_IE_OFS   = 8'h38;

   // Byte offsets of the second port inside the block window.
   localparam logic [ADDR_W-1:0] SP_BASE_OFS = 8'h40;
   localparam logic [ADDR_W-1:0] SP_DATA_OFS = SP_BASE_OFS + 8'h00;
   localparam logic [ADDR_W-1:0] SP_OE_OFS   = SP_BASE_OFS + 8'h04;
   localparam logic [ADDR_W-1:0] SP_FSEL_OFS = SP_BASE_OFS + 8'h08;
   localparam logic [ADDR_W-1:0] SP_RSVD_OFS = SP_BASE_OFS + 8'h10;
   localparam logic [ADDR_W-1:0] SP_PUP_OFS  = SP_BASE_OFS + 8'h2c;
   localparam logic [ADDR_W-1:0] SP_IE_OFS   = SP_BASE_OFS + 8'h38;

   // Read-only boot status word.
   localparam logic [ADDR_W-1:0] BOOT_STAT_OFS = 8'h80;
   localparam int                BOOT_VALID_BIT = 0;
   localparam int                BOOT_FLASH_BIT = 1;

   // Strap pin position on the second port.
   localparam int BOOT_PIN = 0;
   // Pin of the first port that carries external interrupt four.
   localparam int INT_PIN  = 3;

   // Reset values of the control bytes.
   localparam logic [7:0] FP_FSEL_RST = 8'h00;
   localparam logic [7:0] FP_OD_RST   = 8'h00;
   localparam logic [7:0] FP_PUP_RST  = 8'h00;
   localparam logic [7:0] FP_IE_RST   = 8'h00;
   localparam logic [7:0] SP_DATA_RST = 8'h00;
   localparam logic [7:0] SP_OE_RST   = 8'h00;
   localparam logic [7:0] SP_FSEL_RST = 8'h00;
   localparam logic [7:0] SP_PUP_RST  = 8'h01;
   localparam logic [7:0] SP_IE_RST   = 8'h00;
   // Pin-side enables while reset is held: strap input and pull-up on.
   localparam logic [7:0] SP_IN_EN_RST   = 8'h01;
   localparam logic [7:0] SP_PULL_EN_RST = 8'h01;

   // Bus responses.
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Requests from the bus master.
   typedef struct packed {
      logic              awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic              wvalid;
      logic [DATA_W-1:0] wdata;
      logic [3:0]        wstrb;
      logic              bready;
      logic              arvalid;
      logic [ADDR_W-1:0] araddr;
      logic              rready;
   } gph_axi_req_t;

   // Answers to the bus master.
   typedef struct packed {
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        rresp;
   } gph_axi_rsp_t;

   // Pin pad controls of one port.
   typedef struct packed {
      logic [7:0] o;
      logic [7:0] oe;
      logic [7:0] pull_en;
      logic [7:0] in_en;
   } gph_pad_t;

   // Drive request from a source towards the pins.
   typedef struct packed {
      logic [7:0] o;
      logic [7:0] oe;
   } gph_drive_t;

endpackage

// file: test/gph_pin_model.sv
// Pin-side model: pads, pull-ups, external drivers and floating pins.
`timescale 1ns/100ps

module gph_pin_model
(
   // Clock.
   input  wire logic              i_clk,
   // Pad controls from the port.
   input  wire gph_pkg::gph_pad_t i_pad,
   // External drivers commanded by the bench.
   input  wire logic [7:0]        i_ext_en,
   input  wire logic [7:0]        i_ext_val,
   // Resolved pin levels.
   output      logic [7:0]        o_pin
);
   import gph_pkg::*;

   logic [7:0] float_r = 8'h55;

   // A floating pin shows a level that changes every cycle, so no stale value passes.
   always_ff @(posedge i_clk)
      float_r <= ~float_r;

   // An external driver wins, then the pad driver, then the pull-up, else the pin floats.
   always_comb
   begin
      for (int k = 0; k < 8; k++)
      begin
         if (i_ext_en[k])
            o_pin[k] = i_ext_val[k];
         else if (i_pad.oe[k])
            o_pin[k] = i_pad.o[k];
         else if (i_pad.pull_en[k])
            o_pin[k] = 1'b1;
         else
            o_pin[k] = float_r[k];
      end
   end
endmodule

// file: test/gpio_ports_g_h_with_boot_strap_test.sv
// Self-checking bench for the two GPIO ports with boot strap capture.
`timescale 1ns/100ps

module gpio_ports_g_h_with_boot_strap_test;
   import gph_pkg::*;

   logic         ref_clk;
   logic         rstn;
   logic         stop_mode;
   logic [7:0]   fp_ext_en;
   logic [7:0]   fp_ext_val;
   logic [7:0]   sp_ext_en;
   logic [7:0]   sp_ext_val;
   logic [7:0]   fp_pin;
   logic [7:0]   sp_pin;
   gph_axi_req_t req;
   gph_axi_rsp_t rsp;
   gph_pad_t     fp_pad;
   gph_pad_t     sp_pad;
   gph_drive_t   gpio_drv;
   gph_drive_t   alt_drv;
   logic [7:0]   fp_gpio_i;
   logic [7:0]   fp_alt_i;
   logic [7:0]   sp_cap;
   logic         ext_int;
   logic         boot_valid;
   logic         boot_flash;
   logic         boot_rom;
   logic [31:0]  rd;
   logic [7:0]   sel;
   logic [7:0]   nsel;
   int           n_mismatch = 0;
   int           checks_done = 0;

   // Register addresses and their reset values.
   localparam logic [7:0] ADR [9] = '{FP_FSEL_OFS, FP_OD_OFS, FP_PUP_OFS, FP_IE_OFS, SP_DATA_OFS,
                                      SP_OE_OFS, SP_FSEL_OFS, SP_PUP_OFS, SP_IE_OFS};
   localparam logic [7:0] RST [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};

   gph_ports u_gph_ports
   (
      .I_REF_CLK      (ref_clk),
      .I_RSTN         (rstn),
      .I_AXI_REQ      (req),
      .O_AXI_RSP      (rsp),
      .I_FP_PIN_I     (fp_pin),
      .O_FP_PAD       (fp_pad),
      .I_FP_GPIO_DRV  (gpio_drv),
      .O_FP_GPIO_I    (fp_gpio_i),
      .I_FP_ALT_DRV   (alt_drv),
      .O_FP_ALT_I     (fp_alt_i),
      .I_STOP_MODE    (stop_mode),
      .O_EXT_INT_FOUR (ext_int),
      .I_SP_PIN_I     (sp_pin),
      .O_SP_PAD       (sp_pad),
      .O_SP_TIMER_CAP (sp_cap),
      .O_BOOT_VALID   (boot_valid),
      .O_BOOT_FLASH   (boot_flash),
      .O_BOOT_ROM     (boot_rom)
   );

   gph_pin_model u_fp_pins (.i_clk(ref_clk), .i_pad(fp_pad), .i_ext_en(fp_ext_en), .i_ext_val(fp_ext_val),
                            .o_pin(fp_pin));
   gph_pin_model u_sp_pins (.i_clk(ref_clk), .i_pad(sp_pad), .i_ext_en(sp_ext_en), .i_ext_val(sp_ext_val),
                            .o_pin(sp_pin));

   // The 100 MHz clock.
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Counts a comparison and reports a mismatch.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // A bus answer that never came counts as a mismatch.
   task automatic hang;
      n_mismatch++;
      $display("bus wait ran out at %0t", $time);
      stop_test;
   endtask

   // Lets registered outputs follow their cause.
   task automatic settle;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask

   // One write; address and data are offered together and each dropped once taken.
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int   n;
      logic done;
      n = 0;
      done = 1'b0;
      @(posedge ref_clk);
      req.awvalid <= 1'b1;
      req.awaddr  <= a;
      req.wvalid  <= 1'b1;
      req.wdata   <= d;
      req.wstrb   <= 4'hf;
      req.bready  <= 1'b1;
      while (!done && n < 40)
      begin
         @(posedge ref_clk);
         n++;
         if (rsp.awready)
            req.awvalid <= 1'b0;
         if (rsp.wready)
            req.wvalid <= 1'b0;
         if (rsp.bvalid)
         begin
            chk(rsp.bresp, er);
            req.bready <= 1'b0;
            done = 1'b1;
         end
      end
      if (!done)
         hang;
   endtask

   // One read; the data is taken at the edge that sees rvalid.
   task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
      int   n;
      logic done;
      n = 0;
      done = 1'b0;
      @(posedge ref_clk);
      req.arvalid <= 1'b1;
      req.araddr  <= a;
      req.rready  <= 1'b1;
      while (!done && n < 40)
      begin
         @(posedge ref_clk);
         n++;
         if (rsp.arready)
            req.arvalid <= 1'b0;
         if (rsp.rvalid)
         begin
            d = rsp.rdata;
            chk(rsp.rresp, er);
            req.rready <= 1'b0;
            done = 1'b1;
         end
      end
      if (!done)
         hang;
   endtask

   // Reset with the strap held low, or left to the pull-up for a high level.
   task automatic do_reset(input logic strap);
      @(posedge ref_clk);
      rstn       <= 1'b0;
      sp_ext_en  <= {7'h00, !strap};
      sp_ext_val <= 8'h00;
      repeat (2) @(posedge ref_clk);
      #1;
      chk(sp_pad.pull_en, 8'h01);
      chk(sp_pad.in_en, 8'h01);
      @(posedge ref_clk);
      rstn <= 1'b1;
      settle;
      chk(boot_valid, 1'b1);
      chk(boot_flash, strap);
      chk(boot_rom, !strap);
      axi_rd(BOOT_STAT_OFS, RESP_OKAY, rd);
      chk(rd, (32'h1 << BOOT_VALID_BIT) | (32'(strap) << BOOT_FLASH_BIT));
   endtask

   // Main sequence.
   initial
   begin
      req = '0;
      gpio_drv = '0;
      alt_drv = '0;
      stop_mode = 1'b0;
      rstn = 1'b0;
      fp_ext_en = 8'h00;
      fp_ext_val = 8'h00;
      sp_ext_en = 8'h01;
      sp_ext_val = 8'h00;
      do_reset(1'b0);
      axi_wr(SP_DATA_OFS, 32'h0000_0033, RESP_OKAY);
      do_reset(1'b1);
      for (int i = 0; i < 9; i++)
      begin
         axi_rd(ADR[i], RESP_OKAY, rd);
         chk(rd, {24'h0, RST[i]});
      end
      for (int i = 0; i < 9; i++)
      begin
         axi_wr(ADR[i], 32'hffff_ff5a, RESP_OKAY);
         axi_rd(ADR[i], RESP_OKAY, rd);
         chk(rd, 32'h0000_005a);
      end
      settle;
      chk(fp_pad.pull_en, 8'h5a);
      chk(fp_pad.in_en, 8'h5a);
      chk(sp_pad.o, 8'h5a);
      chk(sp_pad.oe, 8'h00);
      chk(sp_pad.pull_en, 8'h5a);
      // Reserved and unmapped places are refused and read as zero.
      foreach (ADR[i])
      begin
         if (i < 2)
         begin
            axi_wr(i == 0 ? SP_RSVD_OFS : 8'h90, 32'hff, RESP_SLVERR);
            axi_rd(i == 0 ? SP_RSVD_OFS : 8'h90, RESP_SLVERR, rd);
            chk(rd, 32'h0);
         end
      end
      // Second port as GPIO: low nibble driven, high nibble read from the pins.
      axi_wr(SP_FSEL_OFS, 32'h00, RESP_OKAY);
      axi_wr(SP_OE_OFS, 32'h0f, RESP_OKAY);
      axi_wr(SP_DATA_OFS, 32'ha5, RESP_OKAY);
      axi_wr(SP_IE_OFS, 32'hf0, RESP_OKAY);
      sp_ext_en  <= 8'hf0;
      sp_ext_val <= 8'h3c;
      settle;
      chk(sp_pad.oe, 8'h0f);
      axi_rd(SP_DATA_OFS, RESP_OKAY, rd);
      chk(rd, 32'h35);
      // Second port routed to timer capture inputs.
      axi_wr(SP_FSEL_OFS, 32'hff, RESP_OKAY);
      axi_wr(SP_IE_OFS, 32'hff, RESP_OKAY);
      sp_ext_en  <= 8'hff;
      sp_ext_val <= 8'h69;
      settle;
      chk(sp_cap, 8'h69);
      chk(sp_pad.oe, 8'h00);
      // First port: each function bit hands one pin to its peripheral.
      axi_wr(FP_IE_OFS, 32'hff, RESP_OKAY);
      axi_wr(FP_OD_OFS, 32'h00, RESP_OKAY);
      fp_ext_en  <= 8'hff;
      fp_ext_val <= 8'hff;
      gpio_drv   <= '{o: 8'h00, oe: 8'hff};
      alt_drv    <= '{o: 8'hff, oe: 8'hff};
      for (int k = 0; k < 8; k++)
      begin
         sel = 8'h01 << k;
         nsel = ~sel;
         axi_wr(FP_FSEL_OFS, {24'h0, sel}, RESP_OKAY);
         settle;
         chk(fp_alt_i, sel);
         chk(fp_gpio_i, nsel);
         chk(fp_pad.o & 8'hf7, sel & 8'hf7);
      end
      // Open-drain drives low only; CMOS drives both levels.
      axi_wr(FP_FSEL_OFS, 32'h00, RESP_OKAY);
      axi_wr(FP_OD_OFS, 32'hff, RESP_OKAY);
      gpio_drv <= '{o: 8'h0f, oe: 8'hff};
      settle;
      chk(fp_pad.o, 8'h00);
      chk(fp_pad.oe, 8'hf0);
      axi_wr(FP_OD_OFS, 32'h00, RESP_OKAY);
      settle;
      chk(fp_pad.o, 8'h0f);
      chk(fp_pad.oe, 8'hff);
      // External interrupt four through the input enable and stop mode.
      chk(ext_int, 1'b1);
      @(posedge ref_clk);
      stop_mode <= 1'b1;
      settle;
      chk(ext_int, 1'b0);
      axi_wr(FP_FSEL_OFS, 32'h08, RESP_OKAY);
      settle;
      chk(ext_int, 1'b1);
      axi_wr(FP_IE_OFS, 32'h00, RESP_OKAY);
      settle;
      chk(ext_int, 1'b0);
      stop_test;
   end
endmodule
